// ==== verilog/tgc_params.svh ====
`ifndef TGC_PARAMS_SVH
`define TGC_PARAMS_SVH

// Register byte offsets
`define TGC_A_ANYCAP   8'h00
`define TGC_A_ANYSEL   8'h04
`define TGC_A_CHCAP    8'h08
`define TGC_A_CHSEL    8'h0C
`define TGC_A_CTRL     8'h10
`define TGC_A_CMD      8'h14
`define TGC_A_DELAY    8'h18
`define TGC_A_MPDIR    8'h1C
`define TGC_A_CHMODE   8'h20
`define TGC_A_STATUS   8'h24

// Widths
`define TGC_AW         8
`define TGC_DW         32
`define TGC_ANY_W      5
`define TGC_CH_W       8
`define TGC_MP_W       3
`define TGC_SYNC_W     21

// Capabilities and reset values
`define TGC_ANY_CAP    5'h1F
`define TGC_CH_CAP     8'hFF
`define TGC_ANY_RST    5'h01
`define TGC_CH_RST     8'h00
`define TGC_CTRL_RST   2'h0
`define TGC_DELAY_RST  32'h00000000
`define TGC_MPOEN_RST  3'h7
`define TGC_CHMODE_RST 8'h00

// Field positions
`define TGC_B_IMM      0
`define TGC_B_MAIN     1
`define TGC_B_EN       0
`define TGC_B_COMB     1
`define TGC_B_START    0
`define TGC_B_FORCE    1
`define TGC_B_STOP     2

`endif

// ==== verilog/tgc_pkg.sv ====
`default_nettype none
`include "tgc_params.svh"

package tgc_pkg;

  // Trigger sequencing states
  typedef enum logic [1:0] {
    TGC_IDLE,
    TGC_ARMED,
    TGC_DELAY
  } tgc_state_e;

  // Whole state of the combiner
  typedef struct packed {
    tgc_state_e                 state;
    logic [`TGC_ANY_W-1:0]      any_sel_r;
    logic [`TGC_CH_W-1:0]       ch_sel_r;
    logic [1:0]                 ctrl_r;
    logic [`TGC_DW-1:0]         delay_r;
    logic [`TGC_MP_W-1:0]       mp_oe_n_r;
    logic [`TGC_CH_W-1:0]       ch_mode_r;
    logic [`TGC_DW-1:0]         cnt_r;
    logic [7:0]                 ext_q_r;
    logic [`TGC_CH_W-1:0]       cha_q_r;
    logic [`TGC_CH_W-1:0]       chw_q_r;
    logic                       remote_q_r;
    logic                       trig_r;
    logic                       evt_r;
    logic [`TGC_MP_W-1:0]       mp_out_r;
    logic [`TGC_DW-1:0]         prdata_r;
    logic                       pready_r;
    logic                       pslverr_r;
  } tgc_state_s;

endpackage : tgc_pkg

`default_nettype wire

// ==== verilog/tgc_sync2.sv ====
`timescale 1ns/1ps
`default_nettype none

module tgc_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
  } tgc_sync_s;

  tgc_sync_s s;
  tgc_sync_s s_nxt;

  // Two stages; only the second is read outside
  always_comb begin
    s_nxt      = s;
    s_nxt.s1_r = d;
    s_nxt.s2_r = s.s1_r;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= s_nxt;
    end
  end

  assign q = s.s2_r;

endmodule : tgc_sync2

`default_nettype wire

// ==== verilog/tgc_trigger_or.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tgc_params.svh"

module tgc_trigger_or
  import tgc_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [`TGC_AW-1:0]    paddr,
  input  wire logic [`TGC_DW-1:0]    pwdata,
  output logic      [`TGC_DW-1:0]    prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  main_trigger_input,
  input  wire logic [`TGC_MP_W-1:0]  multipurpose_line_in,
  output logic      [`TGC_MP_W-1:0]  multipurpose_line_out,
  output logic      [`TGC_MP_W-1:0]  multipurpose_line_oe_n,
  input  wire logic [`TGC_CH_W-1:0]  chan_cmp_lo,
  input  wire logic [`TGC_CH_W-1:0]  chan_cmp_hi,
  input  wire logic                  remote_trig_in,
  output logic                       local_event_out,
  output logic                       trigger_out
);

  tgc_state_s s;
  tgc_state_s s_nxt;

  logic [`TGC_SYNC_W-1:0] sync_q;
  logic                   main_s;
  logic [`TGC_MP_W-1:0]   line_s;
  logic [`TGC_CH_W-1:0]   lo_s;
  logic [`TGC_CH_W-1:0]   hi_s;
  logic                   remote_s;

  // Rising edges of an 8-bit condition vector
  function automatic logic [7:0] rise8(input logic [7:0] cur,
                                       input logic [7:0] prev);
    rise8 = cur & ~prev;
  endfunction : rise8

  // Address match for one register
  function automatic logic hit(input logic [`TGC_AW-1:0] a,
                               input logic [`TGC_AW-1:0] off);
    hit = (a == off);
  endfunction : hit

  // All pin inputs come from outside the clock domain
  tgc_sync2 #(
    .W (`TGC_SYNC_W)
  ) u_tgc_sync2 (
    .clk    (clk),
    .resetn (resetn),
    .d      ({remote_trig_in, chan_cmp_hi, chan_cmp_lo,
              multipurpose_line_in, main_trigger_input}),
    .q      (sync_q)
  );

  assign main_s   = sync_q[0];
  assign line_s   = sync_q[3:1];
  assign lo_s     = sync_q[11:4];
  assign hi_s     = sync_q[19:12];
  assign remote_s = sync_q[20];

  logic                   acc;
  logic                   wr;
  logic                   mapped;
  logic [`TGC_ANY_W-1:0]  any_eff;
  logic [`TGC_CH_W-1:0]   ch_eff;
  logic [7:0]             ext_now;
  logic [7:0]             ext_rise;
  logic [`TGC_CH_W-1:0]   win_now;
  logic [`TGC_CH_W-1:0]   ch_ev;
  logic                   src_any;
  logic                   raw;
  logic                   gated;
  logic                   start_cmd;
  logic                   force_cmd;
  logic                   stop_cmd;
  logic                   remote_ev;
  logic                   armed;
  logic                   ev_now;
  logic [`TGC_DW-1:0]     rd_mux;

  // Bus phase decode; writes land on the completing edge
  assign acc = psel & penable;
  assign wr  = acc & pwrite & s.pready_r;
  assign mapped = hit(paddr, `TGC_A_ANYCAP) | hit(paddr, `TGC_A_ANYSEL) |
                  hit(paddr, `TGC_A_CHCAP)  | hit(paddr, `TGC_A_CHSEL)  |
                  hit(paddr, `TGC_A_CTRL)   | hit(paddr, `TGC_A_CMD)    |
                  hit(paddr, `TGC_A_DELAY)  | hit(paddr, `TGC_A_MPDIR)  |
                  hit(paddr, `TGC_A_CHMODE) | hit(paddr, `TGC_A_STATUS);

  // Commands are one-shot write strobes
  assign start_cmd = wr & hit(paddr, `TGC_A_CMD) & pwdata[`TGC_B_START];
  assign force_cmd = wr & hit(paddr, `TGC_A_CMD) & pwdata[`TGC_B_FORCE];
  assign stop_cmd  = wr & hit(paddr, `TGC_A_CMD) & pwdata[`TGC_B_STOP];

  // Unsupported selections masked off
  assign any_eff = s.any_sel_r & `TGC_ANY_CAP;
  assign ch_eff  = s.ch_sel_r & `TGC_CH_CAP;

  // External conditions; lines only count while inputs
  assign ext_now  = {4'h0, line_s & s.mp_oe_n_r, main_s};
  assign ext_rise = rise8(ext_now, s.ext_q_r);

  // Channel: upper comparator edge or entry to the window
  assign win_now = lo_s & ~hi_s;
  assign ch_ev   = (rise8(hi_s, s.cha_q_r) & ~s.ch_mode_r) |
                   (rise8(win_now, s.chw_q_r) & s.ch_mode_r);

  // Raw OR of every enabled source
  assign src_any = any_eff[`TGC_B_IMM] |
                   (|(any_eff[`TGC_ANY_W-1:`TGC_B_MAIN] &
                      ext_rise[`TGC_ANY_W-2:0]));
  assign raw     = src_any | (|(ch_eff & ch_ev));

  // Enable gate, force override, then other cards
  assign gated     = raw & s.ctrl_r[`TGC_B_EN];
  assign remote_ev = s.ctrl_r[`TGC_B_COMB] &
                     remote_s & ~s.remote_q_r;
  assign armed     = (s.state == TGC_ARMED);
  assign ev_now    = armed & (gated | force_cmd | remote_ev);

  // Read data selection
  always_comb begin
    rd_mux = '0;
    unique case (1'b1)
      hit(paddr, `TGC_A_ANYCAP): rd_mux[`TGC_ANY_W-1:0] = `TGC_ANY_CAP;
      hit(paddr, `TGC_A_ANYSEL): rd_mux[`TGC_ANY_W-1:0] = s.any_sel_r;
      hit(paddr, `TGC_A_CHCAP):  rd_mux[`TGC_CH_W-1:0]  = `TGC_CH_CAP;
      hit(paddr, `TGC_A_CHSEL):  rd_mux[`TGC_CH_W-1:0]  = s.ch_sel_r;
      hit(paddr, `TGC_A_CTRL):   rd_mux[1:0]            = s.ctrl_r;
      hit(paddr, `TGC_A_DELAY):  rd_mux                 = s.delay_r;
      hit(paddr, `TGC_A_MPDIR):  rd_mux[`TGC_MP_W-1:0]  = ~s.mp_oe_n_r;
      hit(paddr, `TGC_A_CHMODE): rd_mux[`TGC_CH_W-1:0]  = s.ch_mode_r;
      hit(paddr, `TGC_A_STATUS): rd_mux[1:0]            = s.state;
      default:                   rd_mux                 = '0;
    endcase
  end

  // Next state of everything
  always_comb begin
    s_nxt = s;
    // Bus answer one cycle into the access phase
    s_nxt.pready_r  = acc & ~s.pready_r;
    s_nxt.pslverr_r = acc & ~s.pready_r & ~mapped;
    if (acc & ~s.pready_r & ~pwrite) begin
      s_nxt.prdata_r = rd_mux;
    end
    // Register writes
    if (wr & hit(paddr, `TGC_A_ANYSEL)) begin
      s_nxt.any_sel_r = pwdata[`TGC_ANY_W-1:0];
    end
    if (wr & hit(paddr, `TGC_A_CHSEL)) begin
      s_nxt.ch_sel_r = pwdata[`TGC_CH_W-1:0];
    end
    if (wr & hit(paddr, `TGC_A_CTRL)) begin
      s_nxt.ctrl_r = pwdata[1:0];
    end
    if (wr & hit(paddr, `TGC_A_DELAY)) begin
      s_nxt.delay_r = pwdata;
    end
    if (wr & hit(paddr, `TGC_A_MPDIR)) begin
      s_nxt.mp_oe_n_r = ~pwdata[`TGC_MP_W-1:0];
    end
    if (wr & hit(paddr, `TGC_A_CHMODE)) begin
      s_nxt.ch_mode_r = pwdata[`TGC_CH_W-1:0];
    end
    // Condition history for edge detection
    s_nxt.ext_q_r    = ext_now;
    s_nxt.cha_q_r    = hi_s;
    s_nxt.chw_q_r    = win_now;
    s_nxt.remote_q_r = remote_s;
    // Pulses default low
    s_nxt.trig_r = 1'b0;
    s_nxt.evt_r  = armed & (gated | force_cmd);
    // Arm, wait, delay
    unique case (s.state)
      TGC_IDLE: begin
        if (start_cmd) begin
          s_nxt.state = TGC_ARMED;
        end
      end
      TGC_ARMED: begin
        if (stop_cmd) begin
          s_nxt.state = TGC_IDLE;
        end else if (ev_now) begin
          if (s.delay_r == `TGC_DELAY_RST) begin
            s_nxt.trig_r = 1'b1;
            s_nxt.state  = TGC_IDLE;
          end else begin
            s_nxt.cnt_r = 32'h00000001;
            s_nxt.state = TGC_DELAY;
          end
        end
      end
      TGC_DELAY: begin
        if (stop_cmd) begin
          s_nxt.state = TGC_IDLE;
        end else if (s.cnt_r == s.delay_r) begin
          s_nxt.trig_r = 1'b1;
          s_nxt.state  = TGC_IDLE;
        end else begin
          s_nxt.cnt_r = s.cnt_r + 32'h00000001;
        end
      end
      default: begin
        s_nxt.state = TGC_IDLE;
      end
    endcase
    // Status on lines set as outputs
    s_nxt.mp_out_r = {s_nxt.trig_r, s_nxt.state == TGC_DELAY,
                      s_nxt.state == TGC_ARMED};
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s           <= '0;
      s.state     <= TGC_IDLE;
      s.any_sel_r <= `TGC_ANY_RST;
      s.ch_sel_r  <= `TGC_CH_RST;
      s.ctrl_r    <= `TGC_CTRL_RST;
      s.delay_r   <= `TGC_DELAY_RST;
      s.mp_oe_n_r <= `TGC_MPOEN_RST;
      s.ch_mode_r <= `TGC_CHMODE_RST;
    end else begin
      s <= s_nxt;
    end
  end

  // Outputs straight from the state
  assign prdata                 = s.prdata_r;
  assign pready                 = s.pready_r;
  assign pslverr                = s.pslverr_r;
  assign trigger_out            = s.trig_r;
  assign local_event_out        = s.evt_r;
  assign multipurpose_line_out  = s.mp_out_r;
  assign multipurpose_line_oe_n = s.mp_oe_n_r;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_evt_nodelay;
    ev_now && (s.delay_r == `TGC_DELAY_RST) && !stop_cmd;
  endsequence

  sequence s_evt_delay3;
    ev_now && (s.delay_r == 32'h00000003) && !stop_cmd;
  endsequence

  a_force_fires: assert property (
    (armed && force_cmd) |-> ev_now)
    else $error("force while armed gave no event");

  a_enable_gate: assert property (
    (armed && !s.ctrl_r[`TGC_B_EN] && !force_cmd && !remote_ev) |-> !ev_now)
    else $error("disabled source produced an event");

  a_nodelay_trig: assert property (
    s_evt_nodelay |=> trigger_out && s.state == TGC_IDLE)
    else $error("zero delay trigger missing");

  a_delay_three: assert property (
    s_evt_delay3 ##1 (!stop_cmd)[*3] |-> !trigger_out ##1 trigger_out)
    else $error("three cycle delay wrong");

  a_cap_filter: assert property (
    (wr && hit(paddr, `TGC_A_ANYSEL)) |=>
      any_eff == ($past(pwdata[`TGC_ANY_W-1:0]) & `TGC_ANY_CAP))
    else $error("unavailable source kept");

  a_imm_start: assert property (
    (start_cmd && s.state == TGC_IDLE && any_eff[`TGC_B_IMM] &&
     s.ctrl_r[`TGC_B_EN] && !(acc && pwrite && hit(paddr, `TGC_A_CTRL)))
    |=> ev_now)
    else $error("immediate source did not fire after start");

  a_chan_or: assert property (
    (armed && ch_eff[0] && ch_ev[0] && s.ctrl_r[`TGC_B_EN]) |-> ev_now)
    else $error("channel zero event lost");

  a_remote_or: assert property (
    (armed && s.ctrl_r[`TGC_B_COMB] && $rose(remote_s)) |-> ev_now)
    else $error("event of another card lost");

  a_mp_dir: assert property (
    (wr && hit(paddr, `TGC_A_MPDIR)) |=>
      multipurpose_line_oe_n == ~$past(pwdata[`TGC_MP_W-1:0]))
    else $error("line direction not applied");

  a_apb_wait: assert property (
    (acc && !pready) |=> pready)
    else $error("bus answer late");

  a_stop_abort: assert property (
    ((s.state != TGC_IDLE) && stop_cmd) |=>
      (!trigger_out && s.state == TGC_IDLE))
    else $error("stop did not abort");

  a_local_pulse: assert property (
    local_event_out |=> !local_event_out)
    else $error("local event longer than one cycle");

  a_trig_pulse: assert property (
    trigger_out |-> (s.state == TGC_IDLE) ##1 !trigger_out)
    else $error("trigger not a single pulse");

  a_idle_quiet: assert property (
    (s.state == TGC_IDLE) |=> (!local_event_out && !trigger_out))
    else $error("event outside armed state");

  a_delay_step: assert property (
    ((s.state == TGC_DELAY) && !stop_cmd && (s.cnt_r != s.delay_r)) |=>
      ((s.state == TGC_DELAY) && (s.cnt_r == $past(s.cnt_r) + 32'h00000001)))
    else $error("delay count did not advance");

  a_window_entry: assert property (
    (armed && ch_eff[0] && s.ch_mode_r[0] && s.ctrl_r[`TGC_B_EN] &&
     $rose(lo_s[0] && !hi_s[0])) |-> ev_now)
    else $error("window entry on channel zero lost");

  a_mp_status: assert property (
    multipurpose_line_out ==
      {trigger_out, s.state == TGC_DELAY, s.state == TGC_ARMED})
    else $error("line status wrong");

endmodule : tgc_trigger_or

`default_nettype wire

// ==== verif/tgc_source_model.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tgc_params.svh"

module tgc_source_model (
  input  wire logic                 clk,
  input  wire logic                 resetn,
  input  wire logic                 fire,
  input  wire logic [3:0]           kind,
  input  wire logic [3:0]           lag,
  output logic                      main_trigger_input,
  output logic [`TGC_MP_W-1:0]      multipurpose_line_in,
  output logic [`TGC_CH_W-1:0]      chan_cmp_lo,
  output logic [`TGC_CH_W-1:0]      chan_cmp_hi,
  output logic                      remote_trig_in
);
  logic [4:0]  cnt_r;
  logic [13:0] pick;
  logic        act;

  // Countdown: lag idle cycles, then four active cycles
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= 5'h00;
    end else if (fire && cnt_r == 5'h00) begin
      cnt_r <= 5'(lag) + 5'h04;
    end else if (cnt_r != 5'h00) begin
      cnt_r <= cnt_r - 5'h01;
    end
  end

  // One source at a time; comparator outputs fall back low after
  assign act = (cnt_r != 5'h00) && (cnt_r <= 5'h04);
  // Kind 13 raises only the lower comparator of channel zero
  assign pick = act ? (14'h0001 << kind) : 14'h0000;
  assign main_trigger_input = pick[0];
  assign multipurpose_line_in = pick[3:1];
  assign chan_cmp_hi = pick[11:4];
  assign chan_cmp_lo = pick[11:4] | {7'h00, pick[13]};
  assign remote_trig_in = pick[12];
endmodule : tgc_source_model

`default_nettype wire

// ==== verif/test_trigger_or_combiner.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tgc_params.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fails++; \
  $display("Error %0t: got %0h want %0h", $time, (a), (e)); end end

module test_trigger_or_combiner;
  logic                 clk, resetn, psel, penable, pwrite, fire;
  logic [`TGC_AW-1:0]   paddr;
  logic [`TGC_DW-1:0]   pwdata, prdata, rd;
  logic                 pready, pslverr, err, main_in, remote;
  logic                 local_evt, trig;
  logic [`TGC_MP_W-1:0] mp_in, mp_out, mp_oe_n;
  logic [`TGC_CH_W-1:0] lo, hi;
  logic [3:0]           kind, lag;
  int                   fails, compares, n;

  tgc_trigger_or u_tgc_trigger_or (.clk(clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .main_trigger_input(main_in), .multipurpose_line_in(mp_in),
    .multipurpose_line_out(mp_out), .multipurpose_line_oe_n(mp_oe_n),
    .chan_cmp_lo(lo), .chan_cmp_hi(hi), .remote_trig_in(remote),
    .local_event_out(local_evt), .trigger_out(trig));

  tgc_source_model u_tgc_source_model (.clk(clk), .resetn(resetn),
    .fire(fire), .kind(kind), .lag(lag), .main_trigger_input(main_in),
    .multipurpose_line_in(mp_in), .chan_cmp_lo(lo), .chan_cmp_hi(hi),
    .remote_trig_in(remote));

  // Clock generator
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task final_report;
    $display("Checks %0d, errors %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report

  // One APB transfer, held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      fails++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wait_trig(input int lim);
    n = 0;
    while (trig !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_trig

  task t_reset;
    `CHK(mp_oe_n, 3'h7)
    apb(0, `TGC_A_ANYCAP, 0); `CHK(rd, 32'h0000001F)
    apb(0, `TGC_A_ANYSEL, 0); `CHK(rd, 32'h00000001)
    apb(0, `TGC_A_CHCAP, 0); `CHK(rd, 32'h000000FF)
    apb(0, `TGC_A_CHSEL, 0); `CHK(rd, 32'h00000000)
    apb(0, 8'hF0, 0); `CHK(err, 1'b1)
    apb(1, `TGC_A_ANYSEL, 32'hFFFFFFFF);
    apb(0, `TGC_A_ANYSEL, 0); `CHK(rd, 32'h0000001F)
    apb(1, `TGC_A_ANYSEL, 32'h00000001);
    apb(1, `TGC_A_MPDIR, 32'h00000001);
    repeat (2) @(posedge clk);
    `CHK(mp_oe_n, 3'h6)
    apb(1, `TGC_A_MPDIR, 32'h00000000);
  endtask : t_reset

  task t_immediate;
    apb(1, `TGC_A_CTRL, 32'h00000001);
    apb(1, `TGC_A_CMD, 32'h00000001);
    wait_trig(20);
    `CHK(trig, 1'b1)
    `CHK(local_evt, 1'b1)
  endtask : t_immediate

  task t_delay;
    apb(1, `TGC_A_DELAY, 32'h00000003);
    apb(1, `TGC_A_CMD, 32'h00000001);
    n = 0;
    while (local_evt !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    wait_trig(20);
    `CHK(n, 3)
  endtask : t_delay

  task t_gate;
    apb(1, `TGC_A_CTRL, 32'h00000000);
    apb(1, `TGC_A_CMD, 32'h00000001);
    wait_trig(15);
    `CHK(trig, 1'b0)
    `CHK(mp_out, 3'h1)
    apb(1, `TGC_A_CMD, 32'h00000002);
    wait_trig(20);
    `CHK(trig, 1'b1)
    `CHK(mp_out, 3'h4)
    apb(1, `TGC_A_DELAY, 32'h00000000);
    apb(1, `TGC_A_CTRL, 32'h00000001);
  endtask : t_gate

  // Arm, let the far side raise one source, expect trigger or silence
  task t_source(input logic [31:0] any, input logic [31:0] ch,
                input logic [3:0] k, input logic exp);
    apb(1, `TGC_A_ANYSEL, any);
    apb(1, `TGC_A_CHSEL, ch);
    apb(1, `TGC_A_CMD, 32'h00000001);
    @(posedge clk);
    fire <= 1'b1; kind <= k; lag <= 4'h3;
    @(posedge clk);
    fire <= 1'b0;
    wait_trig(20);
    `CHK(trig, exp)
    if (!exp) apb(1, `TGC_A_CMD, 32'h00000004);
  endtask : t_source

  // Window mode: only entry into the window counts
  task t_window;
    apb(1, `TGC_A_CHMODE, 32'h00000001);
    t_source(32'h00000000, 32'h00000001, 4'hD, 1'b1);
    t_source(32'h00000000, 32'h00000001, 4'h4, 1'b0);
    apb(1, `TGC_A_CHMODE, 32'h00000000);
  endtask : t_window

  // Other cards trigger only while combining is on
  task t_remote;
    apb(1, `TGC_A_CTRL, 32'h00000003);
    t_source(32'h00000000, 32'h00000000, 4'hC, 1'b1);
    `CHK(local_evt, 1'b0)
    apb(1, `TGC_A_CTRL, 32'h00000001);
    t_source(32'h00000000, 32'h00000000, 4'hC, 1'b0);
  endtask : t_remote

  // Main sequence
  initial begin
    resetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h00000000; fire = 1'b0;
    kind = 4'h0; lag = 4'h0; fails = 0; compares = 0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_immediate();
    t_delay();
    t_gate();
    t_source(32'h00000002, 32'h00000000, 4'h0, 1'b1);
    t_source(32'h00000004, 32'h00000000, 4'h1, 1'b1);
    t_source(32'h00000008, 32'h00000000, 4'h2, 1'b1);
    t_source(32'h00000010, 32'h00000000, 4'h3, 1'b1);
    t_source(32'h00000004, 32'h00000000, 4'h0, 1'b0);
    t_source(32'h00000000, 32'h00000001, 4'h4, 1'b1);
    t_source(32'h00000000, 32'h00000080, 4'hB, 1'b1);
    t_source(32'h00000000, 32'h00000001, 4'hD, 1'b0);
    t_window();
    t_remote();
    final_report();
  end
endmodule : test_trigger_or_combiner

`default_nettype wire
